// ### rtl/ext_phy_pkg.sv
package ext_phy_pkg;

  // ==========================================================
  // sizes
  localparam int PORTS     = 2;
  localparam int ADDR_W    = 11;
  localparam int DATA_W    = 8;

  // ==========================================================
  // field positions in the first quadlet (bit 0 is the lsb)
  localparam int TAG_LSB   = 30;
  localparam int NODE_LSB  = 24;
  localparam int TYPE_LSB  = 18;
  localparam int PAGE_LSB  = 15;
  localparam int PORT_LSB  = 11;
  localparam int REG_LSB   = 8;
  localparam int CMD_LSB   = 0;

  // ==========================================================
  // codes
  localparam logic [1:0] TAG_EXT      = 2'h0;
  localparam logic [3:0] TYPE_BASE    = 4'h1;
  localparam logic [3:0] TYPE_PAGED   = 4'h5;
  localparam logic [3:0] TYPE_CMD     = 4'h8;
  localparam logic [3:0] TYPE_RESUME  = 4'hF;
  localparam logic [3:0] PAGED_BASE   = 4'h8;
  localparam logic [2:0] CMD_NOP      = 3'h0;
  localparam logic [2:0] CMD_NOTIFY   = 3'h1;
  localparam logic [2:0] CMD_SUSPEND  = 3'h2;
  localparam logic [2:0] CMD_RSVD     = 3'h3;
  localparam logic [2:0] CMD_FAULT    = 3'h4;
  localparam logic [2:0] CMD_ENABLE   = 3'h5;
  localparam logic [2:0] CMD_RESUME   = 3'h6;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic [31:0] first;
    logic [31:0] second;
  } rx_pkt_type;

  typedef struct packed {
    logic [5:0]        node;
    logic              paged;
    logic [2:0]        page;
    logic [3:0]        port;
    logic [3:0]        reg_addr;
    logic [DATA_W-1:0] value;
  } reply_type;

  typedef struct packed {
    logic [5:0] node;
    logic [3:0] port;
    logic [2:0] cmd;
  } confirm_type;

  typedef struct packed {
    logic [PORTS-1:0] disable_notice_signal;
    logic [PORTS-1:0] port_off;
    logic [PORTS-1:0] suspend_go;
    logic [PORTS-1:0] fault_clear;
    logic [PORTS-1:0] port_on;
    logic [PORTS-1:0] resume;
  } port_act_type;

endpackage

// ### rtl/extended_phy_packet_handler.sv
`timescale 1ns/1ns
module extended_phy_packet_handler (
  input  wire logic                                ref_clk,
  input  wire logic                                rstn,
  input  wire logic [5:0]                          node_physical_identifier,
  input  wire ext_phy_pkg::rx_pkt_type             pkt_in,
  input  wire logic                                pkt_valid,
  output logic                                     pkt_ready,
  output logic                                     pkt_dropped_q,
  input  wire logic [ext_phy_pkg::PORTS-1:0]       port_connected,
  input  wire logic [ext_phy_pkg::PORTS-1:0]       port_suspended,
  input  wire logic [ext_phy_pkg::PORTS-1:0]       notice_done,
  input  wire logic                                reg_wr_en,
  input  wire logic [ext_phy_pkg::ADDR_W-1:0]      reg_wr_addr,
  input  wire logic [ext_phy_pkg::DATA_W-1:0]      reg_wr_data,
  output ext_phy_pkg::reply_type                   reply_q,
  output logic                                     reply_valid_q,
  output ext_phy_pkg::confirm_type                 confirm_q,
  output logic                                     confirm_valid_q,
  output ext_phy_pkg::port_act_type                act_q
);

  // ==========================================================
  // helpers
  function automatic logic [ext_phy_pkg::PORTS-1:0] port_hot(
    input logic [3:0] port
  );
    logic [ext_phy_pkg::PORTS-1:0] hot;
    hot = '0;
    for (int i = 0; i < ext_phy_pkg::PORTS; i++) begin
      if (port == 4'(i)) begin
        hot[i] = 1'b1;
      end
    end
    return hot;
  endfunction

  // base registers ignore page and port, so they sit in the bottom slot
  function automatic logic [ext_phy_pkg::ADDR_W-1:0] mem_addr(
    input logic       paged,
    input logic [2:0] page,
    input logic [3:0] port,
    input logic [3:0] phys
  );
    logic [ext_phy_pkg::ADDR_W-1:0] a;
    a = paged ? {page, port, phys} : {7'h00, phys};
    return a;
  endfunction

  // ==========================================================
  // packet decode
  typedef enum logic [1:0] {IDLE, READ, NOTIFY} state_type;

  state_type                       state_q;
  state_type                       state_d;
  logic [31:0]                     q0;
  logic                            take;
  logic                            inverse_ok;
  logic                            tag_ok;
  logic                            well_formed;
  logic [5:0]                      pkt_node;
  logic [3:0]                      pkt_type;
  logic [2:0]                      pkt_page;
  logic [3:0]                      pkt_port;
  logic [2:0]                      pkt_reg;
  logic [2:0]                      pkt_cmd;
  logic                            for_me;
  logic                            is_read;
  logic                            is_paged;
  logic                            is_cmd;
  logic                            is_resume;
  logic                            go_notify;
  logic [3:0]                      phys_addr;
  logic [ext_phy_pkg::PORTS-1:0]   hot;
  logic [ext_phy_pkg::PORTS-1:0]   resume_mask;
  logic [ext_phy_pkg::PORTS-1:0]   sel_q;
  logic [2:0]                      cmd_q;
  logic [3:0]                      port_q;
  logic                            notice_seen;
  logic [ext_phy_pkg::DATA_W-1:0]  rd_data;
  ext_phy_pkg::reply_type          meta_q;
  ext_phy_pkg::port_act_type       act_d;

  assign pkt_ready   = (state_q == IDLE);
  assign take        = pkt_valid && pkt_ready;
  assign q0          = pkt_in.first;
  assign inverse_ok  = (pkt_in.second == ~q0);
  assign tag_ok      = (q0[ext_phy_pkg::TAG_LSB +: 2] == ext_phy_pkg::TAG_EXT);
  assign well_formed = take && inverse_ok && tag_ok;
  assign pkt_node    = q0[ext_phy_pkg::NODE_LSB +: 6];
  assign pkt_type    = q0[ext_phy_pkg::TYPE_LSB +: 4];
  assign pkt_page    = q0[ext_phy_pkg::PAGE_LSB +: 3];
  assign pkt_port    = q0[ext_phy_pkg::PORT_LSB +: 4];
  assign pkt_reg     = q0[ext_phy_pkg::REG_LSB +: 3];
  assign pkt_cmd     = q0[ext_phy_pkg::CMD_LSB +: 3];
  assign for_me      = (pkt_node == node_physical_identifier);
  assign is_paged    = (pkt_type == ext_phy_pkg::TYPE_PAGED);
  assign is_read     = well_formed && for_me
                       && (is_paged || pkt_type == ext_phy_pkg::TYPE_BASE);
  assign is_cmd      = well_formed && for_me
                       && (pkt_type == ext_phy_pkg::TYPE_CMD);
  assign is_resume   = well_formed && (pkt_type == ext_phy_pkg::TYPE_RESUME);
  assign phys_addr   = is_paged ? ext_phy_pkg::PAGED_BASE + {1'b0, pkt_reg}
                                : {1'b0, pkt_reg};
  assign hot         = port_hot(pkt_port);
  // a port outside the device has nothing to notify, so confirm at once
  assign go_notify   = is_cmd && pkt_cmd == ext_phy_pkg::CMD_NOTIFY
                       && hot != '0;
  assign resume_mask = port_connected & port_suspended;
  assign notice_seen = (notice_done & sel_q) != '0;

  // ==========================================================
  // register store
  // packet page and port replace the stored choices
  phy_reg_mem u_mem (
    .ref_clk   (ref_clk),
    .wr_en     (reg_wr_en),
    .wr_addr   (reg_wr_addr),
    .wr_data   (reg_wr_data),
    .rd_en     (is_read),
    .rd_addr   (mem_addr(is_paged, pkt_page, pkt_port, phys_addr)),
    .rd_data_q (rd_data)
  );

  // ==========================================================
  // sequencing
  always_comb begin
    state_d = state_q;
    case (state_q)
      IDLE: begin
        if (is_read) begin
          state_d = READ;
        end else if (go_notify) begin
          state_d = NOTIFY;
        end
      end
      READ: begin
        state_d = IDLE;
      end
      NOTIFY: begin
        if (notice_seen) begin
          state_d = IDLE;
        end
      end
      default: begin
        state_d = IDLE;
      end
    endcase
  end

  // per-port actions, all one-cycle pulses
  always_comb begin
    act_d = '0;
    if (is_cmd) begin
      case (pkt_cmd)
        ext_phy_pkg::CMD_NOTIFY:  act_d.disable_notice_signal = hot;
        ext_phy_pkg::CMD_SUSPEND: act_d.suspend_go = hot;
        ext_phy_pkg::CMD_FAULT:   act_d.fault_clear = hot;
        ext_phy_pkg::CMD_ENABLE:  act_d.port_on = hot;
        ext_phy_pkg::CMD_RESUME:  act_d.resume = hot;
        default:                  act_d = '0;
      endcase
    end else if (is_resume) begin
      act_d.resume = resume_mask;
    end
    // disable only after notice went out
    if (state_q == NOTIFY && notice_seen) begin
      act_d.port_off = sel_q;
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= IDLE;
      act_q   <= '0;
      sel_q   <= '0;
      cmd_q   <= ext_phy_pkg::CMD_NOP;
      port_q  <= 4'h0;
      meta_q  <= '0;
    end else begin
      state_q <= state_d;
      act_q   <= act_d;
      if (is_cmd) begin
        sel_q  <= hot;
        cmd_q  <= pkt_cmd;
        port_q <= pkt_port;
      end
      if (is_read) begin
        meta_q <= '{node: node_physical_identifier, paged: is_paged,
                    page: pkt_page, port: pkt_port, reg_addr: phys_addr,
                    value: '0};
      end
    end
  end

  // ==========================================================
  // answers
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reply_valid_q   <= 1'b0;
      reply_q         <= '0;
      confirm_valid_q <= 1'b0;
      confirm_q       <= '0;
      pkt_dropped_q   <= 1'b0;
    end else begin
      pkt_dropped_q <= take && !(inverse_ok && tag_ok);
      reply_valid_q <= (state_q == READ);
      if (state_q == READ) begin
        reply_q       <= meta_q;
        reply_q.value <= rd_data;
      end
      confirm_valid_q <= (is_cmd && !go_notify)
                         || (state_q == NOTIFY && notice_seen);
      if (is_cmd && !go_notify) begin
        confirm_q <= '{node: node_physical_identifier, port: pkt_port,
                       cmd: pkt_cmd};
      end else if (state_q == NOTIFY && notice_seen) begin
        confirm_q <= '{node: node_physical_identifier, port: port_q,
                       cmd: cmd_q};
      end
    end
  end

  // ==========================================================
  // checks
  a_read_reply: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_read |-> ##2 reply_valid_q
      && reply_q.node == $past(node_physical_identifier, 2))
    else $error("remote read did not reply two cycles later");

  a_paged_addr: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_read && is_paged |-> ##2 reply_q.reg_addr == {1'b1, $past(pkt_reg, 2)})
    else $error("paged read used wrong register address");

  a_page_port: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_read |-> ##2 reply_q.page == $past(pkt_page, 2)
      && reply_q.port == $past(pkt_port, 2))
    else $error("reply page or port not taken from packet");

  a_cmd_confirm: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_cmd && !go_notify |=> confirm_valid_q
      && confirm_q.cmd == $past(pkt_cmd))
    else $error("command not confirmed next cycle");

  a_off_after: assert property (@(posedge ref_clk) disable iff (!rstn)
    go_notify |=> act_q.disable_notice_signal != '0 && act_q.port_off == '0)
    else $error("port disabled before the notice went out");

  a_off_order: assert property (@(posedge ref_clk) disable iff (!rstn)
    act_q.port_off != '0 |-> $past(state_q) == NOTIFY && $past(notice_seen))
    else $error("port disabled without a sent notice");

  a_suspend_go: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_cmd && pkt_cmd == ext_phy_pkg::CMD_SUSPEND
      |=> act_q.suspend_go == $past(hot))
    else $error("suspend not started on chosen port");

  a_fault_clr: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_cmd && pkt_cmd == ext_phy_pkg::CMD_FAULT
      |=> act_q.fault_clear == $past(hot))
    else $error("fault bit not cleared on chosen port");

  a_rsvd_quiet: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_cmd && pkt_cmd == ext_phy_pkg::CMD_RSVD |=> act_q == '0)
    else $error("reserved command changed port state");

  a_resume_all: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_resume |=> act_q.resume == $past(resume_mask))
    else $error("resume missed a connected suspended port");

  a_bcast_mute: assert property (@(posedge ref_clk) disable iff (!rstn)
    is_resume |=> !confirm_valid_q ##1 !reply_valid_q)
    else $error("resume packet drew an answer");

  a_drop_bad: assert property (@(posedge ref_clk) disable iff (!rstn)
    take && !inverse_ok |=> act_q == '0 && !confirm_valid_q ##1 !reply_valid_q)
    else $error("packet with bad inverse was acted upon");

  c_read: cover property (@(posedge ref_clk) disable iff (!rstn)
    is_read && is_paged ##2 reply_valid_q);
  c_notify: cover property (@(posedge ref_clk) disable iff (!rstn)
    go_notify ##[1:20] act_q.port_off != '0);
  c_resume: cover property (@(posedge ref_clk) disable iff (!rstn)
    is_resume && resume_mask != '0);

endmodule

// ### rtl/phy_reg_mem.sv
`timescale 1ns/1ns
module phy_reg_mem (
  input  wire logic                                ref_clk,
  input  wire logic                                wr_en,
  input  wire logic [ext_phy_pkg::ADDR_W-1:0]      wr_addr,
  input  wire logic [ext_phy_pkg::DATA_W-1:0]      wr_data,
  input  wire logic                                rd_en,
  input  wire logic [ext_phy_pkg::ADDR_W-1:0]      rd_addr,
  output logic      [ext_phy_pkg::DATA_W-1:0]      rd_data_q
);

  // ==========================================================
  // storage, no reset so it maps onto ram
  logic [ext_phy_pkg::DATA_W-1:0] mem [2**ext_phy_pkg::ADDR_W];

  always_ff @(posedge ref_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (rd_en) begin
      rd_data_q <= mem[rd_addr];
    end
  end

endmodule

// ### verification/extended_phy_packet_handler_tb.sv
`timescale 1ns/1ns
module extended_phy_packet_handler_tb;
  logic                                  ref_clk;
  logic                                  rstn;
  logic [5:0]                            my_id;
  logic [ext_phy_pkg::PORTS-1:0]         conn;
  logic [ext_phy_pkg::PORTS-1:0]         susp;
  logic [ext_phy_pkg::PORTS-1:0]         notice_done;
  logic                                  reg_wr_en;
  logic [ext_phy_pkg::ADDR_W-1:0]        reg_wr_addr;
  logic [ext_phy_pkg::DATA_W-1:0]        reg_wr_data;
  ext_phy_pkg::rx_pkt_type               pkt_in;
  logic                                  pkt_valid;
  logic                                  pkt_ready;
  logic                                  pkt_dropped_q;
  ext_phy_pkg::reply_type                reply_q;
  logic                                  reply_valid_q;
  ext_phy_pkg::confirm_type              confirm_q;
  logic                                  confirm_valid_q;
  ext_phy_pkg::port_act_type             act_q;
  ext_phy_pkg::port_act_type             ea;
  int                                    err_count = 0;
  int                                    tests_run = 0;
  logic [31:0]                           rnd = 32'h00013D41;
  logic [2:0]                            pg;
  logic [2:0]                            rg;
  logic [2:0]                            cm;
  logic [3:0]                            pt;
  logic                                  paged;
  logic [ext_phy_pkg::DATA_W-1:0]        d;
  logic [3:0]                            ra;

  initial begin
    ref_clk = 1'h0;
    forever #5 ref_clk = ~ref_clk;
  end

  remote_node_model node_u (
    .ref_clk     (ref_clk),
    .pkt_ready   (pkt_ready),
    .notice_req  (act_q.disable_notice_signal),
    .pkt_in      (pkt_in),
    .pkt_valid   (pkt_valid),
    .notice_done (notice_done)
  );

  extended_phy_packet_handler dut_u (
    .ref_clk                  (ref_clk),
    .rstn                     (rstn),
    .node_physical_identifier (my_id),
    .pkt_in                   (pkt_in),
    .pkt_valid                (pkt_valid),
    .pkt_ready                (pkt_ready),
    .pkt_dropped_q            (pkt_dropped_q),
    .port_connected           (conn),
    .port_suspended           (susp),
    .notice_done              (notice_done),
    .reg_wr_en                (reg_wr_en),
    .reg_wr_addr              (reg_wr_addr),
    .reg_wr_data              (reg_wr_data),
    .reply_q                  (reply_q),
    .reply_valid_q            (reply_valid_q),
    .confirm_q                (confirm_q),
    .confirm_valid_q          (confirm_valid_q),
    .act_q                    (act_q)
  );

  // ==========================================================
  // helpers
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic [31:0] pkt(input logic [5:0] id,
    input logic [3:0] ty, input logic [2:0] p, input logic [3:0] t,
    input logic [2:0] r, input logic [2:0] c);
    return {2'h0, id, 2'h0, ty, p, t, r, 4'hE, 1'h0, c};
  endfunction

  function automatic ext_phy_pkg::port_act_type exp_act(
    input logic [2:0] c, input logic [3:0] t);
    ext_phy_pkg::port_act_type a;
    logic [ext_phy_pkg::PORTS-1:0] h;
    a = '0;
    h = '0;
    if (t < ext_phy_pkg::PORTS)
      h[t] = 1'h1;
    case (c)
      ext_phy_pkg::CMD_NOTIFY:  a.disable_notice_signal = h;
      ext_phy_pkg::CMD_SUSPEND: a.suspend_go = h;
      ext_phy_pkg::CMD_FAULT:   a.fault_clear = h;
      ext_phy_pkg::CMD_ENABLE:  a.port_on = h;
      ext_phy_pkg::CMD_RESUME:  a.resume = h;
      default:                  a = '0;
    endcase
    return a;
  endfunction

  task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // a sender that never sees ready ends the run
  // returns just after the taking edge, where one-cycle answers stand
  task automatic tx(input logic [31:0] f, input logic [31:0] flip);
    node_u.send(f, flip);
    #1;
    if (node_u.stuck) begin
      err_count++;
      close_out();
    end
  endtask

  // ==========================================================
  // main sequence
  initial begin
    rstn = 1'h0;
    rnd = lfsr(rnd);
    my_id = rnd[5:0];
    conn = '0;
    susp = '0;
    reg_wr_en = 1'h0;
    reg_wr_addr = '0;
    reg_wr_data = '0;
    repeat (4) @(posedge ref_clk);
    rstn <= 1'h1;
    // remote reads, base and paged, random page, port and index
    for (int i = 0; i < 24; i++) begin
      rnd = lfsr(rnd);
      {paged, pg, pt, rg, d} = rnd[18:0];
      @(posedge ref_clk);
      reg_wr_en <= 1'h1;
      reg_wr_data <= d;
      reg_wr_addr <= paged ? {pg, pt, 4'h8 + {1'h0, rg}} : {8'h00, rg};
      @(posedge ref_clk);
      reg_wr_en <= 1'h0;
      ra = paged ? 4'h8 + {1'h0, rg} : {1'h0, rg};
      tx(pkt(my_id, paged ? ext_phy_pkg::TYPE_PAGED : ext_phy_pkg::TYPE_BASE,
             pg, pt, rg, 3'h0), 32'h0);
      chk({reply_valid_q, pkt_ready}, 2'h0);
      tick;
      chk({reply_valid_q, reply_q.paged}, {1'h1, paged});
      chk(reply_q.value, d);
      chk({reply_q.node, reply_q.reg_addr}, {my_id, ra});
      chk({reply_q.page, reply_q.port}, {pg, pt});
      tick;
      chk(reply_valid_q, 1'h0);
    end
    // read and command to another node stay silent
    tx(pkt(my_id ^ 6'h01, ext_phy_pkg::TYPE_BASE, 3'h0, 4'h0, 3'h0, 3'h0), 0);
    tx(pkt(~my_id, ext_phy_pkg::TYPE_CMD, 3'h0, 4'h0, 3'h0, 3'h5), 32'h0);
    chk({reply_valid_q, confirm_valid_q, act_q}, 14'h0000);
    // every command code on both ports and one port out of range
    for (int c = 0; c < 8; c++) begin
      for (int p = 0; p < 3; p++) begin
        rnd = lfsr(rnd);
        cm = c[2:0];
        pt = p[3:0];
        node_u.delay = 1 + rnd[2:0];
        tx(pkt(my_id, ext_phy_pkg::TYPE_CMD, 3'h0, pt, 3'h0, cm), 32'h0);
        chk(act_q, exp_act(cm, pt));
        if (cm == ext_phy_pkg::CMD_NOTIFY && p < ext_phy_pkg::PORTS) begin
          chk({confirm_valid_q, pkt_ready}, 2'h0);
          ea = '0;
          ea.port_off = act_q.disable_notice_signal;
          for (int n = 0; n < 20 && act_q.port_off === '0; n++)
            tick;
          chk({act_q, confirm_valid_q}, {ea, 1'h1});
        end
        else
          chk(confirm_valid_q, 1'h1);
        chk({confirm_q.port, confirm_q.cmd}, {pt, cm});
      end
    end
    // resume broadcast with any id, random connected and suspended ports
    for (int i = 0; i < 12; i++) begin
      rnd = lfsr(rnd);
      @(posedge ref_clk);
      conn <= rnd[1:0];
      susp <= rnd[3:2];
      tx(pkt(rnd[9:4], ext_phy_pkg::TYPE_RESUME, 3'h0, 4'h0, 3'h0, 3'h0), 0);
      ea = '0;
      ea.resume = rnd[1:0] & rnd[3:2];
      chk({act_q, confirm_valid_q}, {ea, 1'h0});
      tick;
      chk(reply_valid_q, 1'h0);
    end
    // broken inverse, then a tag other than 00
    for (int k = 0; k < 2; k++) begin
      rnd = lfsr(rnd);
      tx(pkt(my_id, ext_phy_pkg::TYPE_CMD, 3'h0, 4'h0, 3'h0, 3'h5)
         | (k ? 32'h80000000 : 32'h0), k ? 32'h0 : (rnd | 32'h1));
      chk(pkt_dropped_q, 1'h1);
      chk({act_q, confirm_valid_q}, 13'h0000);
    end
    close_out();
  end
endmodule

// ### verification/remote_node_model.sv
`timescale 1ns/1ns
module remote_node_model (
  input  wire logic                          ref_clk,
  input  wire logic                          pkt_ready,
  input  wire logic [ext_phy_pkg::PORTS-1:0] notice_req,
  output ext_phy_pkg::rx_pkt_type            pkt_in,
  output logic                               pkt_valid,
  output logic [ext_phy_pkg::PORTS-1:0]      notice_done
);
  int unsigned cnt [ext_phy_pkg::PORTS];
  int unsigned delay;
  bit          stuck;

  initial begin
    pkt_in = '0;
    pkt_valid = 1'h0;
    notice_done = '0;
    cnt = '{default: 0};
    delay = 1;
    stuck = 0;
  end

  // ==========================================================
  // port side: the notice takes a few cycles on the wire
  always @(posedge ref_clk) begin
    for (int p = 0; p < ext_phy_pkg::PORTS; p++) begin
      notice_done[p] <= (cnt[p] == 1);
      if (notice_req[p])
        cnt[p] <= delay;
      else if (cnt[p] != 0)
        cnt[p] <= cnt[p] - 1;
    end
  end

  // ==========================================================
  // packet sender
  // second quadlet inverse
  // flip lets a scenario break the inverse on purpose
  task automatic send(input logic [31:0] first, input logic [31:0] flip);
    bit r;
    r = 0;
    @(posedge ref_clk);
    pkt_in <= {first, ~first ^ flip};
    pkt_valid <= 1'h1;
    for (int i = 0; i < 64 && !r; i++) begin
      @(negedge ref_clk);
      r = pkt_ready;
      @(posedge ref_clk);
    end
    stuck = !r;
    pkt_valid <= 1'h0;
    // released bus shows a changed pattern, not the old packet
    pkt_in <= ~pkt_in;
  endtask
endmodule
